// ===== hdl/urt8_pkg.sv
// constants shared by the up/down reload timer
// assumes: ahb-lite word registers, byte address is four times the index
package urt8_pkg;

  // ******************************************************
  // register indexes and address decode
  // ******************************************************
  localparam logic [15:0] TIMER_MODE_CONTROL_IDX = 16'hffc4;
  localparam logic [15:0] TIMER_COUNT_VALUE_IDX  = 16'hffc5;
  localparam logic [15:0] TIMER_IRQ_CONTROL_IDX  = 16'hffc8;
  localparam int          ADDR_IDX_LSB           = 2;
  localparam int          ADDR_IDX_MSB           = 17;

  // ******************************************************
  // mode register fields and reset values
  // ******************************************************
  localparam int         MODE_RELOAD_BIT  = 7;
  localparam int         MODE_DIR_SRC_BIT = 6;
  localparam int         MODE_SW_DIR_BIT  = 5;
  localparam int         MODE_CSEL_MSB    = 2;
  localparam int         MODE_CSEL_LSB    = 0;
  localparam logic [7:0] MODE_RESET       = 8'h18;
  localparam logic [7:0] MODE_RSVD_ONES   = 8'h18;
  localparam logic [2:0] CSEL_RESET       = 3'h0;
  localparam logic [2:0] CSEL_EXTERNAL    = 3'h7;

  // ******************************************************
  // interrupt control register fields
  // ******************************************************
  localparam int IRQ_FLAG_BIT   = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int EDGE_SEL_BIT   = 2;

  // ******************************************************
  // counter values
  // ******************************************************
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_MIN    = 8'h00;

  // ******************************************************
  // prescaler: tick every 2**tap cycles, index = clock select code
  // ******************************************************
  localparam int          PRESCALE_WIDTH = 13;
  localparam int          PRESCALE_TAPS  = 7;
  localparam int unsigned PRESCALE_TAP [PRESCALE_TAPS] = '{13, 11, 9, 8, 7, 5, 3};
  localparam logic [12:0] PRESCALE_RESET = 13'h0000;

  // ******************************************************
  // ahb-lite encodings
  // ******************************************************
  localparam int         HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] HRESP_OKAY        = 2'h0;
  localparam logic [1:0] HRESP_OKAY_ONE    = 2'h0;

endpackage

// ===== hdl/urt8_prescaler.sv
// free running prescaler producing the seven internal count clocks
// assumes: one clock domain, ticks are one-cycle enables
`timescale 1ns/10ps
module urt8_prescaler
(
  // clock and reset
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  // one-cycle ticks, index is the clock select code
  output logic      [urt8_pkg::PRESCALE_TAPS-1:0]   tick
);

  logic [urt8_pkg::PRESCALE_WIDTH-1:0] div_count;
  logic [urt8_pkg::PRESCALE_TAPS-1:0]  next_tick;

  // ******************************************************
  // divider chain
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_count <= urt8_pkg::PRESCALE_RESET;
    else
      div_count <= div_count + 13'h0001;
  end

  // ******************************************************
  // tap decode
  // ******************************************************
  for (genvar i = 0; i < urt8_pkg::PRESCALE_TAPS; i++)
  begin : g_tap
    assign next_tick[i] = &div_count[urt8_pkg::PRESCALE_TAP[i]-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick <= '0;
    else
      tick <= next_tick;
  end

endmodule

// ===== hdl/urt8_timer.sv
// 8-bit up/down interval and auto-reload timer with an ahb-lite register slave
// assumes: single clock hclk at 40 MHz, pins synchronous to hclk, one bus master
//
// Summary of operation
// - 8-bit counter steps up or down by one per selected count tick.
// - clock codes 000..011 pick clock divided by 8192, 2048, 512, 256.
// - clock divided by 128, 32 and 8 are also offered, seven internal sources.
// - code 111 counts event pin edges; edge chosen by the edge select bit.
// - mode bit 7: 0 interval timer (reset), 1 auto-reload.
// - bit 6 low: bit 5 picks up (0) or down (1); high: pin decides.
// - under pin control, high counts down and low counts up.
// - mode bits 4 and 3 read as one, writes ignored.
// - mode register resets to 18 hex.
// - counter readable any time, not directly writable, resets to zero.
// - overflow and underflow set the timer interrupt flag.
// - flag set and enable high raise the interrupt request.
// - writing the reload register loads the counter at once.
// - auto-reload copies the reload value into the counter on each wrap.
// - interval mode wraps to 00 after overflow, ff after underflow.
// - shared address: write goes to reload, read returns counter.
// - reload register is write-only and resets to zero.
// - mode register and counter/reload sit at their two fixed indexes.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
module urt8_timer
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  output logic      [31:0] hrdata,
  // pins
  input  wire logic        event_input_pin,
  input  wire logic        direction_pin,
  // interrupt request
  output logic             timer_irq
);

  // ******************************************************
  // declarations
  // ******************************************************
  logic        reload_mode_select;
  logic        direction_source_select;
  logic        software_direction;
  logic [2:0]  count_clock_select;
  logic [7:0]  timer_count_value;
  logic [7:0]  timer_reload_value;
  logic        timer_irq_flag;
  logic        timer_irq_enable;
  logic        event_edge_select;

  logic        addr_valid;
  logic [15:0] addr_idx;
  logic        wr_pending;
  logic [15:0] wr_idx;
  logic [31:0] next_rdata;

  logic        wr_mode;
  logic        wr_reload;
  logic        wr_irq_ctrl;

  logic [urt8_pkg::PRESCALE_TAPS-1:0] presc_tick;
  logic [7:0]  count_sources;
  logic        event_prev;
  logic        event_tick;
  logic        count_tick;
  logic        count_down;
  logic        at_limit;
  logic        wrap_event;
  logic [7:0]  next_count;
  logic        next_irq_flag;
  logic [7:0]  mode_readback;
  logic [7:0]  irq_ctrl_readback;

  // ******************************************************
  // prescaler
  // ******************************************************
  urt8_prescaler u_prescaler
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (presc_tick)
  );

  // ******************************************************
  // address phase
  // ******************************************************
  assign addr_valid = hsel && hready && htrans[urt8_pkg::HTRANS_ACTIVE_BIT];
  assign addr_idx   = haddr[urt8_pkg::ADDR_IDX_MSB:urt8_pkg::ADDR_IDX_LSB];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_idx     <= '0;
    end
    else if (hready)
    begin
      wr_pending <= addr_valid && hwrite;
      wr_idx     <= addr_idx;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= urt8_pkg::HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= urt8_pkg::HRESP_OKAY;
    end
  end

  // ******************************************************
  // read path
  // ******************************************************
  assign mode_readback = {reload_mode_select, direction_source_select, software_direction,
                          2'b00, count_clock_select} | urt8_pkg::MODE_RSVD_ONES;

  assign irq_ctrl_readback = {5'h00, event_edge_select, timer_irq_enable, timer_irq_flag};

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr_idx)
      urt8_pkg::TIMER_MODE_CONTROL_IDX:
        next_rdata = {24'h00_0000, mode_readback};
      urt8_pkg::TIMER_COUNT_VALUE_IDX:
        next_rdata = {24'h00_0000, timer_count_value};
      urt8_pkg::TIMER_IRQ_CONTROL_IDX:
        next_rdata = {24'h00_0000, irq_ctrl_readback};
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // reads never touch the counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_valid && !hwrite)
      hrdata <= next_rdata;
    else
      hrdata <= 32'h0000_0000;
  end

  // ******************************************************
  // write decode (data phase)
  // ******************************************************
  assign wr_mode     = wr_pending && (wr_idx == urt8_pkg::TIMER_MODE_CONTROL_IDX);
  assign wr_reload   = wr_pending && (wr_idx == urt8_pkg::TIMER_COUNT_VALUE_IDX);
  assign wr_irq_ctrl = wr_pending && (wr_idx == urt8_pkg::TIMER_IRQ_CONTROL_IDX);

  // ******************************************************
  // mode register
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reload_mode_select      <= urt8_pkg::MODE_RESET[urt8_pkg::MODE_RELOAD_BIT];
      direction_source_select <= urt8_pkg::MODE_RESET[urt8_pkg::MODE_DIR_SRC_BIT];
      software_direction      <= urt8_pkg::MODE_RESET[urt8_pkg::MODE_SW_DIR_BIT];
      count_clock_select      <= urt8_pkg::CSEL_RESET;
    end
    else if (wr_mode)
    begin
      reload_mode_select      <= hwdata[urt8_pkg::MODE_RELOAD_BIT];
      direction_source_select <= hwdata[urt8_pkg::MODE_DIR_SRC_BIT];
      software_direction      <= hwdata[urt8_pkg::MODE_SW_DIR_BIT];
      count_clock_select      <= hwdata[urt8_pkg::MODE_CSEL_MSB:urt8_pkg::MODE_CSEL_LSB];
    end
  end

  // ******************************************************
  // reload register
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_reload_value <= urt8_pkg::RELOAD_RESET;
    else if (wr_reload)
      timer_reload_value <= hwdata[7:0];
  end

  // ******************************************************
  // count clock selection
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_prev <= 1'b0;
    else
      event_prev <= event_input_pin;
  end

  // edge select high counts rising edges, low counts falling edges
  assign event_tick = event_edge_select ? (event_input_pin && !event_prev)
                                        : (!event_input_pin && event_prev);

  // code 111 is the event pin, codes 000..110 the prescaler taps
  assign count_sources = {event_tick, presc_tick};
  assign count_tick    = count_sources[count_clock_select];

  // ******************************************************
  // direction
  // ******************************************************
  assign count_down = direction_source_select ? direction_pin
                                              : software_direction;

  // ******************************************************
  // counter
  // ******************************************************
  assign at_limit   = count_down ? (timer_count_value == urt8_pkg::COUNT_MIN)
                                 : (timer_count_value == urt8_pkg::COUNT_MAX);
  assign wrap_event = count_tick && at_limit && !wr_reload;

  // a reload write wins over a tick in the same cycle
  always_comb
  begin
    next_count = timer_count_value;
    if (wr_reload)
      next_count = hwdata[7:0];
    else if (wrap_event && reload_mode_select)
      next_count = timer_reload_value;
    else if (wrap_event && count_down)
      next_count = urt8_pkg::COUNT_MAX;
    else if (wrap_event)
      next_count = urt8_pkg::COUNT_MIN;
    else if (count_tick && count_down)
      next_count = timer_count_value - 8'h01;
    else if (count_tick)
      next_count = timer_count_value + 8'h01;
  end

  // ******************************************************
  // counter register
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_count_value <= urt8_pkg::COUNT_RESET;
    else
      timer_count_value <= next_count;
  end

  // ******************************************************
  // interrupt control register and request
  // ******************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_irq_enable  <= 1'b0;
      event_edge_select <= 1'b0;
    end
    else if (wr_irq_ctrl)
    begin
      timer_irq_enable  <= hwdata[urt8_pkg::IRQ_ENABLE_BIT];
      event_edge_select <= hwdata[urt8_pkg::EDGE_SEL_BIT];
    end
  end

  // ******************************************************
  // interrupt flag
  // ******************************************************
  // set wins over a software clear in the same cycle
  always_comb
  begin
    next_irq_flag = timer_irq_flag;
    if (wrap_event)
      next_irq_flag = 1'b1;
    else if (wr_irq_ctrl && !hwdata[urt8_pkg::IRQ_FLAG_BIT])
      next_irq_flag = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq_flag <= 1'b0;
    else
      timer_irq_flag <= next_irq_flag;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq <= 1'b0;
    else
      timer_irq <= timer_irq_flag && timer_irq_enable;
  end

endmodule

// ===== tb/urt8_timer_assertions.sv
// port checker for the up/down reload timer
// assumes: bound to urt8_timer, hready tied to hreadyout
`timescale 1ns/10ps
module urt8_timer_assertions
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [1:0]  hresp,
  input wire logic [31:0] hrdata,
  // interrupt
  input wire logic        timer_irq
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic tk;
  logic cnt;
  assign tk  = hsel && hready && htrans[1];
  assign cnt = haddr[17:2] == urt8_pkg::TIMER_COUNT_VALUE_IDX;
  property p_okay;
    hresp == urt8_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_rdz;
    hrdata[31:8] == 24'h0;
  endproperty
  a_rdz: assert property (p_rdz) else $error("upper read bits set");
  property p_idle;
    !(tk && !hwrite) |=> hrdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_rsvd;
    tk && !hwrite && haddr[17:2] == urt8_pkg::TIMER_MODE_CONTROL_IDX |=> hrdata[4:3] == 2'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");
  property p_load;
    logic [7:0] d;
    tk && hwrite && cnt ##1 (1, d = hwdata[7:0]) ##1 tk && !hwrite && cnt
      |=> hrdata[7:0] inside {d, d + 8'h1, d - 8'h1};
  endproperty
  a_load: assert property (p_load) else $error("reload not loaded");
  property p_step;
    logic [7:0] v;
    tk && !hwrite && cnt ##1 (1, v = hrdata[7:0]) ##1 tk && !hwrite && cnt
      |=> (hrdata[7:0] - v) inside {8'h0, 8'h1, 8'hff} || v inside {8'h0, 8'hff};
  endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  property p_irq_rst;
    $rose(hresetn) |-> !timer_irq;
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule
bind urt8_timer urt8_timer_assertions u_chk
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .timer_irq(timer_irq)
);

// ===== tb/urt8_pins.sv
// event and direction pin driver for the timer
// assumes: tasks are called just after a rising edge of hclk
`timescale 1ns/10ps
module urt8_pins
(
  // clock
  input wire logic hclk,
  // pins
  output logic     event_input_pin,
  output logic     direction_pin
);
  // ****************
  // pin drive
  // ****************
  initial
  begin
    event_input_pin = 1'b0;
    direction_pin   = 1'b0;
  end
  // level held three cycles so each edge is seen once
  task automatic level(input logic v);
    event_input_pin <= v;
    repeat (3) @(posedge hclk);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      level(1'b1);
      level(1'b0);
    end
  endtask
  task automatic set_dir(input logic down);
    direction_pin <= down;
  endtask
endmodule

// ===== tb/tb_updown_reload_timer8.sv
// self-checking bench for the up/down reload timer
// assumes: urt8_timer, urt8_pins and the checker are compiled
`timescale 1ns/10ps
module tb_updown_reload_timer8;
  // ****************
  // signals and instances
  // ****************
  localparam logic [15:0] MD = urt8_pkg::TIMER_MODE_CONTROL_IDX;
  localparam logic [15:0] CT = urt8_pkg::TIMER_COUNT_VALUE_IDX;
  localparam logic [15:0] IC = urt8_pkg::TIMER_IRQ_CONTROL_IDX;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [1:0]  hresp;
  logic [31:0] hrdata;
  logic        ev;
  logic        dir;
  logic        irq;
  logic [31:0] seed = 32'd92653;
  logic [7:0]  r;
  logic [7:0]  a;
  logic [7:0]  b;
  int          n_errors = 0;
  int          cmp_count = 0;
  always #12.5 hclk = ~hclk;
  urt8_timer DUT
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_input_pin(ev),
    .direction_pin(dir), .timer_irq(irq)
  );
  urt8_pins u_pins (.hclk(hclk), .event_input_pin(ev), .direction_pin(dir));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int divof(input int c);
    int d[7] = '{8192, 2048, 512, 256, 128, 32, 8};
    return d[c];
  endfunction
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'b1, d, x);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] v);
    bus(idx, 1'b0, 8'h0, v);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(MD, a);
    chk("mode reset", a, 8'h18);
    rd(CT, a);
    chk("count reset", a, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      seed = xs(seed);
      r = {seed[7:5], 2'b00, c[2:0]};
      wr(MD, r);
      rd(MD, a);
      chk("mode", a, r | 8'h18);
    end
    wr(MD, 8'h07);
    seed = xs(seed);
    wr(CT, seed[7:0]);
    rd(CT, a);
    rd(CT, b);
    chk("load", a, seed[7:0]);
    chk("count hold", b, seed[7:0]);
    wr(IC, 8'h06);
    wr(CT, 8'hfd);
    u_pins.pulse(3);
    rd(CT, a);
    chk("wrap up", a, 8'h00);
    rd(IC, a);
    chk("flag", a, 8'h07);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(IC, 8'h06);
    rd(IC, a);
    chk("flag clear", a, 8'h06);
    chk("irq clear", {7'h0, irq}, 8'h00);
    wr(MD, 8'h27);
    wr(CT, 8'h01);
    u_pins.pulse(2);
    rd(CT, a);
    chk("wrap down", a, 8'hff);
    wr(IC, 8'h06);
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      r = k ? 8'hff - {4'h0, seed[3:0]} : {4'h0, seed[3:0]};
      u_pins.set_dir(~k[0]);
      wr(MD, k ? 8'he7 : 8'hc7);
      wr(CT, r);
      u_pins.pulse(seed[3:0] + 1);
      rd(CT, a);
      chk("reload", a, r);
      rd(IC, a);
      chk("reload flag", a, 8'h07);
      wr(IC, 8'h06);
    end
    wr(MD, 8'h07);
    for (int e = 1; e >= 0; e--)
    begin
      wr(IC, {5'h0, e[0], 2'b00});
      wr(CT, 8'h00);
      u_pins.level(1'b1);
      rd(CT, a);
      chk("edge rise", a, {7'h0, e[0]});
      u_pins.level(1'b0);
      rd(CT, a);
      chk("edge fall", a, 8'h01);
    end
    for (int c = 0; c < 7; c++)
    begin
      wr(MD, 8'h18 | {5'h0, c[2:0]});
      rd(CT, a);
      // the two address-phase edges lie exactly 4 periods apart
      repeat (4 * divof(c) - 2) @(posedge hclk);
      rd(CT, b);
      chk("rate", b - a, 8'h04);
    end
    tally_and_finish();
  end
endmodule
